// *** design/tsw_pkg.sv ***
// Notes on behaviour
// [RULE_01] slave only, open-drain, never drives clock
// [RULE_02] master starts only when bus idle
// [RULE_03] data falling while clock high is START
// [RULE_04] data rising while clock high is STOP
// [RULE_05] data changes only while clock low
// [RULE_06] bytes msb first plus ninth acknowledge bit
// [RULE_07] acknowledge holds data low through clock high
// [RULE_08] master nack ends read, device releases data
// [RULE_09] works at standard and fast clock rates
// [RULE_10] control byte: type, three selects, direction
// [RULE_11] acknowledge only on type and select match
// [RULE_12] any byte count per transfer accepted
// [RULE_13] repeated START expects fresh control byte
// [RULE_14] write: control, command, data bytes acknowledged
// [RULE_15] read: command write, repeated START, read control
// [RULE_16] temperature read returns result, high byte first
// [RULE_17] high setpoint command loads or returns two bytes
// [RULE_18] low setpoint command loads or returns two bytes
// [RULE_19] configuration command writes or returns one byte
// [RULE_20] start command begins single or continuous conversion
// [RULE_21] stop command finishes current conversion then idles
// [RULE_22] mode bit one single, zero continuous, reset zero
// [RULE_23] setpoints are left-justified 12-bit two's complement
// [RULE_24] after mismatch ignore bus until next START
package tsw_pkg;
  // device type code, arbitrary value
  localparam logic [3:0] TYPE_CODE = 4'h5;
  localparam logic [7:0] CMD_TEMP = 8'hAA;
  localparam logic [7:0] CMD_HIGH = 8'hA1;
  localparam logic [7:0] CMD_LOW = 8'hA2;
  localparam logic [7:0] CMD_CFG = 8'hAC;
  localparam logic [7:0] CMD_START = 8'h51;
  localparam logic [7:0] CMD_STOP = 8'h22;
  localparam logic [15:0] HIGH_RESET = 16'h5000;
  localparam logic [15:0] LOW_RESET = 16'h4B00;
  localparam logic [7:0] CFG_RESET = 8'h0E;
  localparam logic [7:0] CFG_WMASK = 8'h6F;
  localparam int CFG_MODE_BIT = 0;
  localparam int CFG_USED_BIT = 4;
  localparam logic [3:0] SEL_LSB_MASK = 4'hF;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [11:0] SETPOINT_LOW_MASK = 12'hFF0;
  typedef enum logic [1:0] {TSW_IDLE, TSW_SINGLE, TSW_CONT} tsw_conv_t;
  typedef enum {TSW_WAIT, TSW_BITS, TSW_ACK, TSW_TXACK} tsw_phase_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } tsw_bus_t;
  typedef struct packed {
    logic start_pulse;
    logic stop_pulse;
  } tsw_conv_req_t;
endpackage

// *** design/tsw_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsw_slave (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // two-wire pins
  input wire tsw_pkg::tsw_bus_t bus_in,
  output logic sda_out,
  output logic sda_oe,
  output logic scl_out,
  output logic scl_oe,
  // straps
  input wire logic device_select_bit2,
  input wire logic device_select_bit1,
  input wire logic device_select_bit0,
  // conversion engine
  input wire logic [15:0] conv_result,
  input wire logic conv_result_valid,
  input wire logic conv_busy,
  output tsw_pkg::tsw_conv_req_t conv_req,
  output tsw_pkg::tsw_conv_t conv_state,
  // stored settings
  output logic [15:0] high_trip_setpoint,
  output logic [15:0] low_trip_setpoint,
  output logic [7:0] config_out
);
  tsw_pkg::tsw_bus_t prev_reg;
  tsw_pkg::tsw_phase_t phase_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_reg;
  logic first_reg;
  logic read_reg;
  logic ctl_done_reg;
  logic cmd_done_reg;
  logic [7:0] cmd_reg;
  logic [1:0] byte_reg;
  logic [15:0] temp_reg;
  logic [7:0] rx_hold_reg;
  // set once bit 0 of a transmitted byte is on the line
  logic tx_end_reg;
  logic start_det, stop_det, rise, fall;
  logic ctl_match;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  // bus conditions sampled against the previous clock
  assign start_det = prev_reg.sda & ~bus_in.sda & prev_reg.scl & bus_in.scl; // see [RULE_03]
  assign stop_det = ~prev_reg.sda & bus_in.sda & prev_reg.scl & bus_in.scl; // see [RULE_04]
  assign rise = ~prev_reg.scl & bus_in.scl; // see [RULE_09]
  assign fall = prev_reg.scl & ~bus_in.scl;
  assign rx_byte = {shift_reg[6:0], bus_in.sda};
  assign ctl_match = rx_byte[7:4] == tsw_pkg::TYPE_CODE &&
    rx_byte[3:1] == {device_select_bit2, device_select_bit1, device_select_bit0}; // see [RULE_11]
  // scl is never driven
  always_ff @(posedge mclk) begin
    scl_out <= 1'b0; // see [RULE_01]
    scl_oe <= 1'b0;
  end
  always_comb begin
    tx_byte = 8'h00;
    unique case (cmd_reg)
      tsw_pkg::CMD_TEMP: tx_byte = byte_reg[0] ? temp_reg[7:0] : temp_reg[15:8]; // see [RULE_16]
      tsw_pkg::CMD_HIGH: tx_byte = byte_reg[0] ? high_trip_setpoint[7:0]
        : high_trip_setpoint[15:8]; // see [RULE_17]
      tsw_pkg::CMD_LOW: tx_byte = byte_reg[0] ? low_trip_setpoint[7:0]
        : low_trip_setpoint[15:8]; // see [RULE_18]
      tsw_pkg::CMD_CFG: tx_byte = config_out; // see [RULE_19]
      default: tx_byte = 8'hFF;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prev_reg <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      prev_reg <= bus_in;
    end
  end
  // bit engine; rising clock edges sample, falling edges shift out
  always_ff @(posedge mclk) begin
    if (sys_rst || stop_det) begin
      phase_reg <= tsw_pkg::TSW_WAIT;
      sda_oe <= 1'b0;
      first_reg <= 1'b0;
      read_reg <= 1'b0;
      ctl_done_reg <= 1'b0;
      bit_reg <= 3'h0;
      shift_reg <= 8'h00;
      byte_reg <= 2'h0;
      tx_end_reg <= 1'b0;
    end else if (start_det) begin // see [RULE_13] [RULE_24]
      phase_reg <= tsw_pkg::TSW_BITS;
      sda_oe <= 1'b0;
      first_reg <= 1'b1; // see [RULE_10]
      read_reg <= 1'b0;
      ctl_done_reg <= 1'b0;
      bit_reg <= 3'h0;
      byte_reg <= 2'h0;
      tx_end_reg <= 1'b0;
    end else begin
      unique case (phase_reg)
        tsw_pkg::TSW_WAIT: sda_oe <= 1'b0;
        tsw_pkg::TSW_BITS: begin
          if (rise && !read_reg) begin // see [RULE_05] [RULE_06]
            shift_reg <= rx_byte;
            bit_reg <= bit_reg + 3'h1;
          end
          // release after bit 0 so the master's acknowledge is sampled
          if (fall && read_reg) begin
            if (tx_end_reg) begin
              sda_oe <= 1'b0; // see [RULE_08]
              tx_end_reg <= 1'b0;
              phase_reg <= tsw_pkg::TSW_TXACK;
            end else begin
              sda_oe <= ~shift_reg[7];
              shift_reg <= {shift_reg[6:0], 1'b1};
              bit_reg <= bit_reg + 3'h1;
              tx_end_reg <= bit_reg == tsw_pkg::BIT_LAST;
            end
          end
          if (rise && !read_reg && bit_reg == tsw_pkg::BIT_LAST) begin
            if (first_reg && !ctl_match) begin
              phase_reg <= tsw_pkg::TSW_WAIT; // see [RULE_24]
            end else begin
              phase_reg <= tsw_pkg::TSW_ACK;
              rx_hold_reg <= rx_byte;
            end
          end
        end
        tsw_pkg::TSW_ACK: begin
          // drive low from this falling edge to the next one
          if (fall && !sda_oe) begin
            sda_oe <= 1'b1; // see [RULE_07]
          end else if (fall) begin
            sda_oe <= 1'b0;
            first_reg <= 1'b0;
            ctl_done_reg <= first_reg;
            if (first_reg && rx_hold_reg[0]) begin
              read_reg <= 1'b1;
              sda_oe <= ~tx_byte[7];
              shift_reg <= {tx_byte[6:0], 1'b1};
              bit_reg <= 3'h1;
              byte_reg <= 2'h0;
            end else if (!first_reg && cmd_done_reg) begin
              // saturate so surplus bytes never wrap onto a register write
              if (byte_reg != 2'h3) begin
                byte_reg <= byte_reg + 2'h1; // see [RULE_12]
              end
            end
            phase_reg <= tsw_pkg::TSW_BITS;
          end
        end
        tsw_pkg::TSW_TXACK: begin
          if (fall) begin
            sda_oe <= 1'b0;
          end
          if (rise) begin
            if (bus_in.sda) begin
              phase_reg <= tsw_pkg::TSW_WAIT; // see [RULE_08]
            end else begin
              phase_reg <= tsw_pkg::TSW_BITS;
              byte_reg <= byte_reg + 2'h1;
            end
          end
        end
      endcase
      if (phase_reg == tsw_pkg::TSW_TXACK && rise && !bus_in.sda) begin
        shift_reg <= cmd_reg == tsw_pkg::CMD_CFG ? config_out
          : (byte_reg[0] ? 8'hFF : tx_byte_next_low());
        bit_reg <= 3'h0;
      end
    end
  end
  function automatic logic [7:0] tx_byte_next_low();
    logic [7:0] v;
    v = 8'hFF;
    unique case (cmd_reg)
      tsw_pkg::CMD_TEMP: v = temp_reg[7:0];
      tsw_pkg::CMD_HIGH: v = high_trip_setpoint[7:0];
      tsw_pkg::CMD_LOW: v = low_trip_setpoint[7:0];
      default: v = 8'hFF;
    endcase
    return v;
  endfunction
  // the first byte after the control byte of a write is the command
  logic rx_commit;
  assign rx_commit = phase_reg == tsw_pkg::TSW_ACK && fall && sda_oe && !first_reg &&
    !read_reg && !start_det && !stop_det;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmd_reg <= 8'h00;
      cmd_done_reg <= 1'b0;
    end else if (start_det) begin
      cmd_done_reg <= 1'b0;
    end else if (rx_commit && !cmd_done_reg) begin
      cmd_reg <= rx_hold_reg; // see [RULE_14] [RULE_15]
      cmd_done_reg <= 1'b1;
    end
  end
  // register writes from data bytes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      high_trip_setpoint <= tsw_pkg::HIGH_RESET;
      low_trip_setpoint <= tsw_pkg::LOW_RESET;
    end else if (rx_commit && cmd_done_reg && byte_reg < 2'h2) begin
      unique case (cmd_reg)
        tsw_pkg::CMD_HIGH: begin
          if (byte_reg[0]) begin
            high_trip_setpoint[7:0] <= rx_hold_reg & tsw_pkg::SETPOINT_LOW_MASK[7:0]; // see [RULE_23]
          end else begin
            high_trip_setpoint[15:8] <= rx_hold_reg; // see [RULE_17]
          end
        end
        tsw_pkg::CMD_LOW: begin
          if (byte_reg[0]) begin
            low_trip_setpoint[7:0] <= rx_hold_reg & tsw_pkg::SETPOINT_LOW_MASK[7:0]; // see [RULE_23]
          end else begin
            low_trip_setpoint[15:8] <= rx_hold_reg; // see [RULE_18]
          end
        end
        default: ;
      endcase
    end
  end
  // configuration and conversion control
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      config_out <= tsw_pkg::CFG_RESET; // see [RULE_22]
      conv_state <= tsw_pkg::TSW_IDLE;
      conv_req <= '0;
      temp_reg <= 16'h0000;
    end else begin
      conv_req <= '0;
      if (conv_result_valid) begin
        temp_reg <= conv_result;
        if (conv_state == tsw_pkg::TSW_SINGLE) begin
          conv_state <= tsw_pkg::TSW_IDLE; // see [RULE_20] [RULE_21]
        end
      end
      if (rx_commit && cmd_done_reg && byte_reg == 2'h0 && cmd_reg == tsw_pkg::CMD_CFG) begin
        config_out <= (rx_hold_reg & tsw_pkg::CFG_WMASK) |
          (config_out & ~tsw_pkg::CFG_WMASK); // see [RULE_19]
      end
      if (rx_commit && !cmd_done_reg && rx_hold_reg == tsw_pkg::CMD_START) begin
        conv_req.start_pulse <= 1'b1;
        config_out[tsw_pkg::CFG_USED_BIT] <= 1'b1;
        conv_state <= config_out[tsw_pkg::CFG_MODE_BIT] ? tsw_pkg::TSW_SINGLE
          : tsw_pkg::TSW_CONT; // see [RULE_20] [RULE_22]
      end
      if (rx_commit && !cmd_done_reg && rx_hold_reg == tsw_pkg::CMD_STOP) begin
        conv_req.stop_pulse <= 1'b1;
        // a conversion in flight completes before going idle
        conv_state <= conv_busy ? tsw_pkg::TSW_SINGLE : tsw_pkg::TSW_IDLE; // see [RULE_21]
      end
    end
  end
  // drive low only through sda_oe, output level is always low
  always_ff @(posedge mclk) begin
    sda_out <= 1'b0; // see [RULE_01]
  end
endmodule
`default_nettype wire

// *** dv/tsw_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsw_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // watched ports
  input wire tsw_pkg::tsw_bus_t bus_in,
  input wire logic sda_oe,
  input wire logic scl_oe,
  input wire logic conv_result_valid,
  input wire tsw_pkg::tsw_conv_req_t conv_req,
  input wire tsw_pkg::tsw_conv_t conv_state,
  input wire logic [15:0] high_trip_setpoint,
  input wire logic [15:0] low_trip_setpoint,
  input wire logic [7:0] config_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  AST_SCL_FREE: assert property (!scl_oe)
    else $error("clock line driven");
  AST_OE_MOVES_LOW: assert property ($changed(sda_oe) |-> !bus_in.scl && !$past(bus_in.scl))
    else $error("data moved while clock high");
  AST_HOLD_WHILE_HIGH: assert property (sda_oe && bus_in.scl |=> sda_oe)
    else $error("data released during clock high");
  AST_QUIET_AFTER_START: assert property ($past(bus_in.scl) && bus_in.scl && $fell(bus_in.sda)
    |=> !sda_oe [*3]) else $error("data driven after start");
  AST_STOP_RELEASE: assert property ($past(bus_in.scl) && bus_in.scl && $rose(bus_in.sda)
    |=> !sda_oe) else $error("data driven after stop");
  AST_NIBBLE: assert property (high_trip_setpoint[3:0] == 4'h0 && low_trip_setpoint[3:0] == 4'h0)
    else $error("setpoint low nibble set");
  AST_START_MODE: assert property (conv_req.start_pulse |=> conv_state ==
    (config_out[tsw_pkg::CFG_MODE_BIT] ? tsw_pkg::TSW_SINGLE : tsw_pkg::TSW_CONT))
    else $error("conversion mode wrong");
  AST_DONE_IDLE: assert property (conv_state == tsw_pkg::TSW_SINGLE && conv_result_valid
    |=> conv_state == tsw_pkg::TSW_IDLE) else $error("no idle after result");
  AST_STOP_HALTS: assert property (conv_req.stop_pulse |=> conv_state != tsw_pkg::TSW_CONT)
    else $error("still continuous after stop");
  cover property (conv_req.start_pulse);
  cover property (conv_req.stop_pulse);
  cover property ($rose(sda_oe));
endmodule
bind tsw_slave tsw_monitor i_tsw_monitor (.mclk, .sys_rst, .bus_in, .sda_oe, .scl_oe,
  .conv_result_valid, .conv_req, .conv_state, .high_trip_setpoint, .low_trip_setpoint,
  .config_out);
`default_nettype wire

// *** dv/tsw_mst.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsw_mst (
  // clock
  input wire logic mclk,
  // slave line drivers
  input wire logic sda_oe,
  input wire logic scl_oe,
  // resolved pins and sampled frames
  output var tsw_pkg::tsw_bus_t bus,
  output var logic [8:0] frame,
  output var logic frame_valid
);
  logic scl_drv = 1'b1;
  logic sda_drv = 1'b1;
  int quarter = 4;
  // pull-ups: a released line reads high
  assign bus = {scl_drv && !scl_oe, sda_drv && !sda_oe};
  initial frame_valid = 1'b0;
  task automatic gap();
    repeat (quarter) @(posedge mclk);
    #1;
  endtask
  // also serves as repeated start; data rises only while clock low
  task automatic start();
    sda_drv = 1'b1;
    gap();
    scl_drv = 1'b1;
    gap();
    sda_drv = 1'b0;
    gap();
    scl_drv = 1'b0;
    gap();
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    gap();
    scl_drv = 1'b1;
    gap();
    sda_drv = 1'b1;
    gap();
  endtask
  // byte plus acknowledge slot, msb first; a one releases the line
  task automatic xfer(input logic [8:0] tx);
    for (int i = 8; i >= 0; i--) begin
      sda_drv = tx[i];
      gap();
      scl_drv = 1'b1;
      gap();
      frame[i] = bus.sda;
      gap();
      scl_drv = 1'b0;
      gap();
    end
    frame_valid = 1'b1;
    @(posedge mclk);
    #1;
    frame_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** dv/test_tsw_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_tsw_slave;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] sel = 3'h0;
  logic [15:0] conv_result = 16'h0000;
  logic conv_result_valid = 1'b0;
  logic conv_busy = 1'b0;
  tsw_pkg::tsw_bus_t bus;
  logic sda_oe, scl_oe, frame_valid;
  logic [8:0] frame;
  tsw_pkg::tsw_conv_req_t conv_req;
  tsw_pkg::tsw_conv_t conv_state;
  logic [15:0] high_trip_setpoint, low_trip_setpoint;
  logic [7:0] config_out;
  logic [8:0] notes[$];
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  always #2.5 mclk = ~mclk;
  tsw_slave i_tsw_slave (.mclk, .sys_rst, .bus_in(bus), .sda_out(), .sda_oe, .scl_out(),
    .scl_oe, .device_select_bit2(sel[2]), .device_select_bit1(sel[1]),
    .device_select_bit0(sel[0]), .conv_result, .conv_result_valid, .conv_busy, .conv_req,
    .conv_state, .high_trip_setpoint, .low_trip_setpoint, .config_out);
  tsw_mst i_tsw_mst (.mclk, .sda_oe, .scl_oe, .bus, .frame, .frame_valid);
  task automatic report_and_stop();
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      report_and_stop();
    end
    if (frame_valid === 1'b1) begin
      check(16'(frame), notes.size() > 0 ? 16'(notes.pop_front()) : 16'hFFFF);
    end
  end
  // note the nine sampled bits, then run the frame; reads release the data bits
  task automatic fr(input logic [7:0] d, input logic ack, input logic rd);
    notes.push_back({d, !ack});
    i_tsw_mst.xfer({rd ? 8'hFF : d, rd ? !ack : 1'b1});
  endtask
  task automatic cmd(input logic [7:0] c, input logic rw);
    i_tsw_mst.start();
    fr({tsw_pkg::TYPE_CODE, sel, 1'b0}, 1'b1, 1'b0);
    fr(c, 1'b1, 1'b0);
    if (rw) begin
      i_tsw_mst.start();
      fr({tsw_pkg::TYPE_CODE, sel, 1'b1}, 1'b1, 1'b0);
    end
  endtask
  task automatic pulse_result(input logic [15:0] v);
    conv_result = v;
    conv_result_valid = 1'b1;
    @(posedge mclk);
    #1;
    conv_result_valid = 1'b0;
  endtask
  initial begin
    logic [15:0] v;
    logic [7:0] c;
    void'($urandom(2));
    sel = 3'($urandom());
    repeat (5) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    check(high_trip_setpoint, tsw_pkg::HIGH_RESET);
    check(low_trip_setpoint, tsw_pkg::LOW_RESET);
    check(16'(config_out), 16'(tsw_pkg::CFG_RESET));
    for (int k = 0; k < 2; k++) begin
      c = k ? tsw_pkg::CMD_LOW : tsw_pkg::CMD_HIGH;
      v = 16'($urandom());
      cmd(c, 1'b0);
      fr(v[15:8], 1'b1, 1'b0);
      fr(v[7:0], 1'b1, 1'b0);
      // surplus bytes must be acknowledged and never land in a register
      repeat (3) fr(8'h5A, 1'b1, 1'b0);
      i_tsw_mst.stop();
      v[3:0] = 4'h0;
      check(k ? low_trip_setpoint : high_trip_setpoint, v);
      cmd(c, 1'b1);
      fr(v[15:8], 1'b1, 1'b1);
      fr(v[7:0], 1'b0, 1'b1);
      i_tsw_mst.stop();
    end
    c = 8'($urandom()) | 8'h01;
    cmd(tsw_pkg::CMD_CFG, 1'b0);
    fr(c, 1'b1, 1'b0);
    i_tsw_mst.stop();
    cmd(tsw_pkg::CMD_CFG, 1'b1);
    fr(c & tsw_pkg::CFG_WMASK, 1'b0, 1'b1);
    i_tsw_mst.stop();
    cmd(tsw_pkg::CMD_START, 1'b0);
    i_tsw_mst.stop();
    check(16'(conv_state), 16'(tsw_pkg::TSW_SINGLE));
    v = 16'($urandom()) & 16'hFFF0;
    pulse_result(v);
    check(16'(conv_state), 16'(tsw_pkg::TSW_IDLE));
    cmd(tsw_pkg::CMD_TEMP, 1'b1);
    fr(v[15:8], 1'b1, 1'b1);
    fr(v[7:0], 1'b0, 1'b1);
    i_tsw_mst.stop();
    i_tsw_mst.quarter = 125;
    cmd(tsw_pkg::CMD_TEMP, 1'b1);
    fr(v[15:8], 1'b0, 1'b1);
    i_tsw_mst.stop();
    i_tsw_mst.quarter = 4;
    cmd(tsw_pkg::CMD_CFG, 1'b0);
    fr(8'h00, 1'b1, 1'b0);
    cmd(tsw_pkg::CMD_START, 1'b0);
    i_tsw_mst.stop();
    check(16'(conv_state), 16'(tsw_pkg::TSW_CONT));
    conv_busy = 1'b1;
    cmd(tsw_pkg::CMD_STOP, 1'b0);
    i_tsw_mst.stop();
    check(16'(conv_state), 16'(tsw_pkg::TSW_SINGLE));
    conv_busy = 1'b0;
    pulse_result(16'h1910);
    check(16'(conv_state), 16'(tsw_pkg::TSW_IDLE));
    i_tsw_mst.start();
    fr({tsw_pkg::TYPE_CODE, ~sel, 1'b0}, 1'b0, 1'b0);
    fr(tsw_pkg::CMD_CFG, 1'b0, 1'b0);
    i_tsw_mst.start();
    fr({~tsw_pkg::TYPE_CODE, sel, 1'b1}, 1'b0, 1'b0);
    i_tsw_mst.stop();
    check(16'(notes.size()), 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
